//--- rtl/sdc_pkg.sv
// Shared constants, field layout and helpers for the daisy-chain serial port.
package sdc_pkg;

  // ==========================================================================
  // Word layout
  // ==========================================================================
  localparam int CMD_W = 16;
  localparam int DATA_W = 16;
  localparam int SLOT_W = 32;
  localparam int POS_W = 7;
  localparam int ADDR_W = 5;
  localparam int BIT_W = 13;
  localparam int RW_BIT = 15;
  localparam int RSV_HI = 14;
  localparam int RSV_LO = 13;
  localparam int RST_BIT = 12;
  localparam int POS_HI = 11;
  localparam int POS_LO = 5;
  localparam int ADDR_HI = 4;
  localparam int ADDR_LO = 0;
  localparam int MAX_CHAIN = 127;

  // ==========================================================================
  // Slot positions, fill patterns and reset values
  // ==========================================================================
  localparam logic [4:0] CMD_LAST = 5'h0F;
  localparam logic [4:0] SLOT_LAST = 5'h1F;
  localparam int RESET_BITS = 64;
  localparam int RD_TAIL = 16;
  localparam logic [DATA_W-1:0] FILL_WORD = 16'hFFFF;
  localparam logic [DATA_W-1:0] REG_DEFAULT = 16'h0000;
  localparam logic [SLOT_W-1:0] LINE_IDLE = 32'hFFFFFFFF;
  localparam logic [ADDR_W-1:0] TRI_REG_ADDR = 5'h1F;
  localparam int TRI_BIT = 2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_MIN_PERIOD_NS = 100;
  localparam int SCK_HALF_MIN_CYC =
    (SCK_MIN_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
  // The return line passes a two-stage synchroniser, so a half period
  // shorter than two system clocks would sample stale data.
  localparam int SYNC_MARGIN_CYC = 2;
  localparam int SCK_HALF_DEF =
    (SCK_HALF_MIN_CYC > SYNC_MARGIN_CYC) ? SCK_HALF_MIN_CYC : SYNC_MARGIN_CYC;

  // ==========================================================================
  // Command word helpers
  // ==========================================================================
  function automatic logic [POS_W-1:0] f_pos(input logic [CMD_W-1:0] w);
    f_pos = w[POS_HI:POS_LO];
  endfunction

  // Filler words carry ones in the reserved bits and are never commands.
  function automatic logic f_is_cmd(input logic [CMD_W-1:0] w);
    f_is_cmd = (w[RSV_HI:RSV_LO] == 2'h0);
  endfunction

  function automatic logic [CMD_W-1:0] f_dec(input logic [CMD_W-1:0] w);
    logic [CMD_W-1:0] r;
    r = w;
    r[POS_HI:POS_LO] = f_pos(w) - 7'h01;
    f_dec = r;
  endfunction

endpackage

//--- rtl/sdc_if.sv
// Link between the serial master and the daisy-chain device port.
`timescale 1ns/1ps
`default_nettype none

interface sdc_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // A released return line floats high through the board pull-up.
  assign miso_line = miso_oe ? miso : 1'b1;

  modport host(output sck, output cs_n, output mosi, input miso_line);
  modport dev(input sck, input cs_n, input mosi, output miso,
              output miso_oe);
endinterface

`default_nettype wire

//--- rtl/sdc_dev.sv
// Daisy-chain serial port slave: the device end of the link.
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Functional notes
// [R01] Lone device always gets chain position zero.
// [R02] Write: command, data, then 32 high cycles.
// [R03] Reset-bit-low command restores registers to defaults.
// [R04] Select bit zero writes, one reads.
// [R05] Master keeps both reserved bits at zero.
// [R06] Normal commands carry the reset bit high.
// [R07] Read data follows 32 high input cycles.
// [R08] Up to 127 devices chained output to input.
// [R09] Decode chain position; zero is first device.
// [R10] Output repeats input exactly 32 clocks later.
// [R11] Forwarded command carries chain position minus one.
// [R12] Execute only when received chain position is zero.
// [R13] Master sends one command per addressed device.
// [R14] Write at N needs 32N plus 64 cycles.
// [R15] Read-all: each command followed by 16 highs.
// [R16] Addressed read puts register contents onto chain.
// [R17] Read at N of K: data after 32K+16.
// [R18] Mode zero: rise samples, fall drives, MSB first.
// [R19] Optional bit floats output while port idle.
// [R20] Layout: rw15, reserved14:13, reset12, pos11:5, addr4:0.
// [R21] Executed read replaces the slot after command.

module sdc_dev #(
  parameter int NREG = 32
) (
  sdc_if.dev link,
  input wire logic clk,
  input wire logic rst_n,
  output logic upd_valid_ff,
  output logic [sdc_pkg::ADDR_W-1:0] upd_addr_ff,
  output logic [sdc_pkg::DATA_W-1:0] upd_data_ff,
  output logic cmd_reset_ff
);
  import sdc_pkg::*;

  // ==========================================================================
  // Reset into the link domain
  // ==========================================================================
  logic rs1_ff, rs2_ff;
  logic nxt_rs1, nxt_rs2;
  logic sck_rst;

  // Two stages bring the system reset onto the serial clock.
  always_comb begin
    nxt_rs1 = rst_n;
    nxt_rs2 = rs1_ff;
  end

  always_ff @(posedge link.sck) begin
    rs1_ff <= nxt_rs1;
    rs2_ff <= nxt_rs2;
  end

  assign sck_rst = ~rs2_ff;

  // ==========================================================================
  // Frame logic: slot counter, delay line and read insertion
  // ==========================================================================
  logic [4:0] cnt_ff, nxt_cnt;
  logic [SLOT_W-1:0] dl_ff, nxt_dl;
  logic [DATA_W-1:0] rd_sh_ff, nxt_rd_sh;
  logic rd_act_ff, nxt_rd_act;
  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic [CMD_W-1:0] word;
  logic slot_cmd, hit, do_wr, do_rst;
  logic [DATA_W-1:0] regs_ff [NREG];

  // The newest sixteen input bits, completed by the bit now on the line.
  assign word = {dl_ff[CMD_W-2:0], link.mosi};

  // Every 32-bit slot opens with a command half; fillers are skipped.
  always_comb begin
    slot_cmd = (cnt_ff == CMD_LAST) && f_is_cmd(word); // see [R20]
    hit = slot_cmd && (f_pos(word) == 7'h00); // see [R09] see [R12]
    do_rst = hit && !word[RST_BIT]; // see [R03]
    do_wr = wr_pend_ff && (cnt_ff == SLOT_LAST);
    nxt_cnt = cnt_ff + 5'h01;
    // Input bits are sampled on the rising edge, MSB first. see [R18]
    nxt_dl = {dl_ff[SLOT_W-2:0], rd_act_ff ? rd_sh_ff[DATA_W-1] : link.mosi};
    nxt_rd_sh = {rd_sh_ff[DATA_W-2:0], 1'b1};
    nxt_rd_act = rd_act_ff;
    nxt_wr_pend = wr_pend_ff;
    nxt_wr_addr = wr_addr_ff;
    if (rd_act_ff && (cnt_ff == SLOT_LAST)) begin
      nxt_rd_act = 1'b0;
    end
    if (do_wr) begin
      nxt_wr_pend = 1'b0;
    end
    if (slot_cmd) begin
      // Rewrite the copy already in the line before it leaves. see [R11]
      nxt_dl[CMD_W-1:0] = f_dec(word);
    end
    if (hit && word[RST_BIT]) begin
      if (word[RW_BIT]) begin // see [R04]
        // Register value takes the place of the next sixteen bits.
        nxt_rd_sh = regs_ff[word[ADDR_HI:ADDR_LO]]; // see [R16] see [R07]
        nxt_rd_act = 1'b1; // see [R21]
      end else begin
        nxt_wr_pend = 1'b1; // see [R02]
        nxt_wr_addr = word[ADDR_HI:ADDR_LO];
      end
    end
    if (sck_rst) begin
      nxt_cnt = 5'h00;
      nxt_dl = LINE_IDLE;
      nxt_rd_act = 1'b0;
      nxt_wr_pend = 1'b0;
    end
  end

  // A raised select clears framing at once, since the serial clock may
  // stop right after the last bit and no later edge can be counted on.
  always_ff @(posedge link.sck or posedge link.cs_n) begin
    if (link.cs_n) begin
      cnt_ff <= 5'h00;
      dl_ff <= LINE_IDLE;
      rd_sh_ff <= FILL_WORD;
      rd_act_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 5'h00;
    end else begin
      cnt_ff <= nxt_cnt; // see [R08]
      dl_ff <= nxt_dl; // see [R10]
      rd_sh_ff <= nxt_rd_sh;
      rd_act_ff <= nxt_rd_act;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [DATA_W-1:0] nxt_regs [NREG];
  logic upd_tgl_ff, nxt_upd_tgl;
  logic rst_tgl_ff, nxt_rst_tgl;
  logic [ADDR_W-1:0] lw_addr_ff, nxt_lw_addr;
  logic [DATA_W-1:0] lw_data_ff, nxt_lw_data;
  logic tri_on;

  // A reset command wins over a write landing in the same cycle.
  always_comb begin
    nxt_regs = regs_ff;
    nxt_upd_tgl = upd_tgl_ff;
    nxt_rst_tgl = rst_tgl_ff;
    nxt_lw_addr = lw_addr_ff;
    nxt_lw_data = lw_data_ff;
    if (sck_rst || do_rst) begin
      for (int i = 0; i < NREG; i++) begin
        nxt_regs[i] = REG_DEFAULT; // see [R03]
      end
      nxt_rst_tgl = rst_tgl_ff ^ do_rst;
    end else if (do_wr) begin
      nxt_regs[wr_addr_ff] = word;
      nxt_upd_tgl = ~upd_tgl_ff;
      nxt_lw_addr = wr_addr_ff;
      nxt_lw_data = word;
    end
    if (sck_rst) begin
      nxt_upd_tgl = 1'b0;
      nxt_rst_tgl = 1'b0;
    end
  end

  always_ff @(posedge link.sck) begin
    regs_ff <= nxt_regs;
    upd_tgl_ff <= nxt_upd_tgl;
    rst_tgl_ff <= nxt_rst_tgl;
    lw_addr_ff <= nxt_lw_addr;
    lw_data_ff <= nxt_lw_data;
  end

  assign tri_on = regs_ff[TRI_REG_ADDR][TRI_BIT];

  // ==========================================================================
  // Serial output, driven on the falling edge
  // ==========================================================================
  logic sdo_ff, nxt_sdo;
  logic oe_ff, nxt_oe;
  logic oe_clr;

  // Both terms come from flip-flops, so the release term cannot glitch.
  assign oe_clr = link.cs_n & tri_on; // see [R19]

  always_comb begin
    nxt_sdo = dl_ff[SLOT_W-1];
    nxt_oe = 1'b1;
    if (sck_rst) begin
      nxt_sdo = 1'b1;
    end
  end

  // Output changes only on falling edges so the next stage samples a
  // settled bit on its rising edge. see [R18]
  always_ff @(negedge link.sck) begin
    sdo_ff <= nxt_sdo;
  end

  always_ff @(negedge link.sck or posedge oe_clr) begin
    if (oe_clr) begin
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= nxt_oe;
    end
  end

  assign link.miso = sdo_ff;
  assign link.miso_oe = oe_ff;

  // ==========================================================================
  // Update reports into the system clock domain
  // ==========================================================================
  logic [1:0] s1_ff, s2_ff, s3_ff;
  logic [1:0] nxt_s1, nxt_s2, nxt_s3;
  logic nxt_upd_valid, nxt_cmd_reset;
  logic [ADDR_W-1:0] nxt_upd_addr;
  logic [DATA_W-1:0] nxt_upd_data;

  // Toggles cross by two stages; the last-write word is stable for a
  // whole slot after its toggle, far longer than the crossing takes.
  always_comb begin
    nxt_s1 = {rst_tgl_ff, upd_tgl_ff};
    nxt_s2 = s1_ff;
    nxt_s3 = s2_ff;
    nxt_upd_valid = s2_ff[0] ^ s3_ff[0];
    nxt_cmd_reset = s2_ff[1] ^ s3_ff[1];
    nxt_upd_addr = upd_addr_ff;
    nxt_upd_data = upd_data_ff;
    if (nxt_upd_valid) begin
      nxt_upd_addr = lw_addr_ff;
      nxt_upd_data = lw_data_ff;
    end
    if (!rst_n) begin
      nxt_s1 = 2'h0;
      nxt_s2 = 2'h0;
      nxt_s3 = 2'h0;
      nxt_upd_valid = 1'b0;
      nxt_cmd_reset = 1'b0;
      nxt_upd_addr = 5'h00;
      nxt_upd_data = REG_DEFAULT;
    end
  end

  always_ff @(posedge clk) begin
    s1_ff <= nxt_s1;
    s2_ff <= nxt_s2;
    s3_ff <= nxt_s3;
    upd_valid_ff <= nxt_upd_valid;
    cmd_reset_ff <= nxt_cmd_reset;
    upd_addr_ff <= nxt_upd_addr;
    upd_data_ff <= nxt_upd_data;
  end

endmodule

`default_nettype wire

//--- rtl/sdc_host.sv
// Serial master for the daisy-chain port: makes the link clock and frames.
`timescale 1ns/1ps
`default_nettype none

module sdc_host #(
  parameter int SCK_HALF = sdc_pkg::SCK_HALF_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  sdc_if.host link,
  input wire logic req_valid,
  input wire logic req_rw,
  input wire logic req_reset,
  input wire logic [sdc_pkg::POS_W-1:0] req_pos,
  input wire logic [sdc_pkg::ADDR_W-1:0] req_addr,
  input wire logic [sdc_pkg::DATA_W-1:0] req_data,
  input wire logic [sdc_pkg::POS_W:0] chain_len,
  output logic busy_ff,
  output logic rsp_valid_ff,
  output logic [sdc_pkg::DATA_W-1:0] rsp_data_ff
);
  import sdc_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_LEAD = 4'b0010,
    H_SHIFT = 4'b0100,
    H_TRAIL = 4'b1000
  } sdc_hst_t;

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  sdc_hst_t st_ff, nxt_st;
  logic [7:0] div_ff, nxt_div;
  logic sck_ff, nxt_sck, cs_n_ff, nxt_cs_n, mosi_ff, nxt_mosi;
  logic [SLOT_W-1:0] sh_ff, nxt_sh;
  logic fill_ff, nxt_fill, rd_ff, nxt_rd;
  logic [BIT_W-1:0] bit_ff, nxt_bit, last_ff, nxt_last, cap_ff, nxt_cap;
  logic [DATA_W-1:0] rx_ff, nxt_rx, nxt_rsp_data;
  logic nxt_busy, nxt_rsp_valid;
  logic ms1_ff, ms2_ff;
  logic tick;
  logic [POS_W-1:0] pos;
  logic [POS_W:0] k;
  logic [CMD_W-1:0] cmd;

  always_comb begin
    tick = (div_ff == 8'(SCK_HALF - 1));
    k = (chain_len == 8'h00) ? 8'h01 : chain_len;
    pos = (k == 8'h01) ? 7'h00 : req_pos; // see [R01] see [R13]
    // Reserved bits zero, reset bit always high; a reset request sends an all-zero frame instead.
    cmd = {req_rw, 2'h0, 1'b1, pos, req_addr}; // see [R05] see [R06] see [R20]
    nxt_st = st_ff;
    nxt_div = tick ? 8'h00 : div_ff + 8'h01;
    nxt_sck = sck_ff;
    nxt_cs_n = cs_n_ff;
    nxt_mosi = mosi_ff;
    nxt_sh = sh_ff;
    nxt_fill = fill_ff;
    nxt_rd = rd_ff;
    nxt_bit = bit_ff;
    nxt_last = last_ff;
    nxt_cap = cap_ff;
    nxt_rx = rx_ff;
    nxt_busy = busy_ff;
    nxt_rsp_valid = 1'b0;
    nxt_rsp_data = rsp_data_ff;
    case (st_ff)
      H_IDLE: begin
        nxt_div = 8'h00;
        if (req_valid) begin
          nxt_st = H_LEAD;
          nxt_busy = 1'b1;
          nxt_cs_n = 1'b0;
          nxt_bit = 13'h0000;
          nxt_fill = 1'b1;
          nxt_rd = 1'b0;
          if (req_reset) begin
            // A line held low for a whole frame is a reset command.
            nxt_sh = 32'h00000000; // see [R03]
            nxt_fill = 1'b0;
            nxt_last = 13'(RESET_BITS - 1);
          end else if (!req_rw) begin
            nxt_sh = {cmd, req_data}; // see [R04] see [R02]
            nxt_last = 13'(SLOT_W * (32'(pos) + 2) - 1); // see [R14]
          end else begin
            nxt_sh = {cmd, FILL_WORD}; // see [R15]
            nxt_rd = 1'b1;
            nxt_last = 13'(SLOT_W * (32'(k) + 1) - 1); // see [R17]
            nxt_cap = 13'(SLOT_W * 32'(k) + RD_TAIL); // see [R07]
          end
          nxt_mosi = nxt_sh[SLOT_W-1];
        end
      end
      H_LEAD: begin
        if (tick) begin
          nxt_st = H_SHIFT;
        end
      end
      H_SHIFT: begin
        if (tick) begin
          nxt_sck = ~sck_ff;
          if (sck_ff) begin
            // Falling edge: the synchronised return bit is settled here.
            if (rd_ff && (bit_ff >= cap_ff)) begin
              nxt_rx = {rx_ff[DATA_W-2:0], ms2_ff};
            end
            if (bit_ff == last_ff) begin
              nxt_st = H_TRAIL;
            end else begin
              nxt_bit = bit_ff + 13'h0001;
              nxt_sh = {sh_ff[SLOT_W-2:0], fill_ff};
              nxt_mosi = sh_ff[SLOT_W-2]; // see [R18]
            end
          end
        end
      end
      H_TRAIL: begin
        if (tick) begin
          nxt_st = H_IDLE;
          nxt_cs_n = 1'b1;
          nxt_busy = 1'b0;
          nxt_rsp_valid = rd_ff;
          nxt_rsp_data = rx_ff;
        end
      end
      default: begin
        nxt_st = H_IDLE;
      end
    endcase
    if (!rst_n) begin
      nxt_st = H_IDLE;
      nxt_div = 8'h00;
      nxt_sck = 1'b0;
      nxt_cs_n = 1'b1;
      nxt_mosi = 1'b1;
      nxt_busy = 1'b0;
      nxt_rsp_valid = 1'b0;
      nxt_rsp_data = 16'h0000;
      nxt_rx = 16'h0000;
      nxt_rd = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
    div_ff <= nxt_div;
    sck_ff <= nxt_sck;
    cs_n_ff <= nxt_cs_n;
    mosi_ff <= nxt_mosi;
    sh_ff <= nxt_sh;
    fill_ff <= nxt_fill;
    rd_ff <= nxt_rd;
    bit_ff <= nxt_bit;
    last_ff <= nxt_last;
    cap_ff <= nxt_cap;
    rx_ff <= nxt_rx;
    busy_ff <= nxt_busy;
    rsp_valid_ff <= nxt_rsp_valid;
    rsp_data_ff <= nxt_rsp_data;
  end

  // Return line comes from another domain; two stages before use.
  always_ff @(posedge clk) begin
    ms1_ff <= link.miso_line;
    ms2_ff <= ms1_ff;
  end

  assign link.sck = sck_ff;
  assign link.cs_n = cs_n_ff;
  assign link.mosi = mosi_ff;

endmodule

`default_nettype wire

//--- verification/sdc_link_props.sv
// Concurrent checks on the serial link between host and device port.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Link checker
// ============================================================================
module sdc_link_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic miso_line
);
  import sdc_pkg::*;

  logic [8:0] cnt_ff, nxt_cnt, len_ff, nxt_len;
  logic [31:0] in_ff, nxt_in;
  logic [6:0] out_ff, nxt_out;
  logic [15:0] rcmd_ff, nxt_rcmd;
  logic [4:0] k;
  logic is_cmd, rd_exec;

  // ==========================================================================
  // Frame history
  // ==========================================================================
  // Command of the slot now leaving, held while its copy is checked.
  always_comb begin
    k = cnt_ff[4:0];
    nxt_cnt = (cnt_ff == 9'h1FF) ? cnt_ff : cnt_ff + 9'h001;
    nxt_in = {in_ff[30:0], mosi};
    nxt_out = {out_ff[5:0], miso_line};
    nxt_rcmd = (k == 5'h00) ? in_ff[31:16] : rcmd_ff;
    nxt_len = (!rst_n) ? 9'h000 : (cs_n ? len_ff : cnt_ff);
    is_cmd = (rcmd_ff[RSV_HI:RSV_LO] == 2'h0);
    rd_exec = is_cmd && rcmd_ff[RW_BIT] && rcmd_ff[RST_BIT] &&
      (rcmd_ff[POS_HI:POS_LO] == 7'h00);
  end

  // History is dropped at once when the frame ends, as the device does.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      cnt_ff <= 9'h000;
      in_ff <= 32'h00000000;
      out_ff <= 7'h00;
      rcmd_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      in_ff <= nxt_in;
      out_ff <= nxt_out;
      rcmd_ff <= nxt_rcmd;
    end
  end

  // Frame length as seen from the system clock.
  always_ff @(posedge clk) begin
    len_ff <= nxt_len;
  end

  // ==========================================================================
  // Properties
  // ==========================================================================
  property p_fwd_head;
    @(posedge sck) disable iff (!rst_n)
    (cnt_ff >= 9'h020) && ((k < 5'h04) || (k inside {[5'h0B:5'h0F]}))
    |-> (miso_line == in_ff[31]);
  endproperty
  a_fwd_head: assert property (p_fwd_head)
    else $error("Command head not repeated 32 clocks later");

  property p_pos_dec;
    @(posedge sck) disable iff (!rst_n)
    (cnt_ff >= 9'h020) && (k == 5'h0B) && is_cmd
    |-> (out_ff == rcmd_ff[POS_HI:POS_LO] - 7'h01);
  endproperty
  a_pos_dec: assert property (p_pos_dec)
    else $error("Forwarded chain position not reduced by one");

  property p_pos_keep;
    @(posedge sck) disable iff (!rst_n)
    (cnt_ff >= 9'h020) && (k == 5'h0B) && !is_cmd
    |-> (out_ff == rcmd_ff[POS_HI:POS_LO]);
  endproperty
  a_pos_keep: assert property (p_pos_keep)
    else $error("Filler word altered on the way through");

  property p_fwd_data;
    @(posedge sck) disable iff (!rst_n)
    (cnt_ff >= 9'h030) && (k >= 5'h10) && !rd_exec
    |-> (miso_line == in_ff[31]);
  endproperty
  a_fwd_data: assert property (p_fwd_data)
    else $error("Data half changed although no read was executed");

  property p_miso_fall;
    @(posedge clk) disable iff (!rst_n)
    $changed(miso) |-> !sck;
  endproperty
  a_miso_fall: assert property (p_miso_fall)
    else $error("Serial output moved while the link clock was high");

  property p_mosi_low;
    @(posedge clk) disable iff (!rst_n)
    $changed(mosi) |-> !sck;
  endproperty
  a_mosi_low: assert property (p_mosi_low)
    else $error("Serial input moved while the link clock was high");

  property p_sck_idle;
    @(posedge clk) disable iff (!rst_n)
    cs_n |-> !sck;
  endproperty
  a_sck_idle: assert property (p_sck_idle)
    else $error("Link clock not resting low outside a frame");

  property p_oe_drive;
    @(posedge sck) disable iff (!rst_n)
    (cnt_ff != 9'h000) |-> miso_oe;
  endproperty
  a_oe_drive: assert property (p_oe_drive)
    else $error("Serial output not driven inside a frame");

  property p_frame_len;
    @(posedge clk) disable iff (!rst_n)
    $rose(cs_n) |-> (len_ff[4:0] == 5'h00) && (len_ff >= 9'h040);
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("Frame is not a whole number of 32-bit slots");

endmodule

`default_nettype wire

//--- verification/sdc_test.sv
// Self-checking bench: host and device port joined on one link.
`timescale 1ns/1ps
`default_nettype none

// ============================================================================
// Bench top
// ============================================================================
module sdc_test;
  import sdc_pkg::*;

  logic clk, rst_n, dev_rst_n, chk_rst_n, quiet;
  logic req_valid, req_rw, req_reset;
  logic [POS_W-1:0] req_pos;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_data;
  logic [POS_W:0] chain_len;
  logic busy_ff, rsp_valid_ff, upd_valid_ff, cmd_reset_ff;
  logic [DATA_W-1:0] rsp_data_ff, upd_data_ff;
  logic [ADDR_W-1:0] upd_addr_ff;
  logic [15:0] rd_q[$];
  logic [20:0] wr_q[$];
  logic [15:0] mem [32];
  logic [4:0] a [4];
  int rs_exp, fail_count, comparisons, seed;

  sdc_if link();

  sdc_host #(.SCK_HALF(2)) sdc_host_inst (.clk(clk), .rst_n(rst_n),
    .link(link.host), .req_valid(req_valid), .req_rw(req_rw),
    .req_reset(req_reset), .req_pos(req_pos), .req_addr(req_addr),
    .req_data(req_data), .chain_len(chain_len), .busy_ff(busy_ff),
    .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff));

  sdc_dev #(.NREG(32)) sdc_dev_inst (.link(link.dev), .clk(clk),
    .rst_n(dev_rst_n), .upd_valid_ff(upd_valid_ff),
    .upd_addr_ff(upd_addr_ff), .upd_data_ff(upd_data_ff),
    .cmd_reset_ff(cmd_reset_ff));

  sdc_link_props sdc_link_props_inst (.clk(clk), .rst_n(chk_rst_n),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso(link.miso), .miso_oe(link.miso_oe),
    .miso_line(link.miso_line));

  // ==========================================================================
  // Compare and closing tasks
  // ==========================================================================
  task automatic cmp_word(input string name, input logic [15:0] exp,
                          input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_upd(input string name, input logic [20:0] exp,
                         input logic [20:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cmp_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ==========================================================================
  // Request drivers
  // ==========================================================================
  // The request is held until the host shows busy, then the frame is awaited.
  task automatic req(input logic rw, input logic rs, input logic [6:0] pos,
                     input logic [4:0] ad, input logic [15:0] d,
                     input logic [7:0] len);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_rw = rw;
    req_reset = rs;
    req_pos = pos;
    req_addr = ad;
    req_data = d;
    chain_len = len;
    while (busy_ff !== 1'b1 && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    req_valid = 1'b0;
    if (busy_ff !== 1'b1) n = 3000;
    while (busy_ff !== 1'b0 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    cmp_bit("frame done", 1'b1, n < 3000);
  endtask

  task automatic wr(input logic [4:0] ad, input logic [15:0] d,
                    input logic [6:0] pos, input logic [7:0] len,
                    input logic exec);
    if (exec) begin
      wr_q.push_back({ad, d});
      mem[ad] = d;
    end
    req(1'b0, 1'b0, pos, ad, d, len);
  endtask

  task automatic rd(input logic [4:0] ad);
    rd_q.push_back(mem[ad]);
    req(1'b1, 1'b0, 7'h00, ad, 16'h0000, 8'h01);
  endtask

  // ==========================================================================
  // Clock, monitor and watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Every result pulse takes the oldest note of its kind.
  initial begin
    forever begin
      @(posedge clk);
      #2;
      if (!quiet && rsp_valid_ff === 1'b1) begin
        cmp_bit("read noted", 1'b1, rd_q.size() > 0);
        if (rd_q.size() > 0)
          cmp_word("read", rd_q.pop_front(), rsp_data_ff);
      end
      if (!quiet && upd_valid_ff === 1'b1) begin
        cmp_bit("write noted", 1'b1, wr_q.size() > 0);
        if (wr_q.size() > 0)
          cmp_upd("write", wr_q.pop_front(),
                  {upd_addr_ff, upd_data_ff});
      end
      if (!quiet && cmd_reset_ff === 1'b1) begin
        cmp_bit("reset noted", 1'b1, rs_exp > 0);
        rs_exp--;
      end
    end
  end

  // Twenty-two frames of under 400 clocks, nine times over.
  initial begin
    #8000000;
    fail_count++;
    close_out();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    seed = 32'h9f8582c0;
    {rst_n, dev_rst_n, chk_rst_n, quiet} = 4'h1;
    {req_valid, req_rw, req_reset} = 3'h0;
    req_pos = 7'h00;
    req_addr = 5'h00;
    req_data = 16'h0000;
    chain_len = 8'h01;
    foreach (mem[i]) mem[i] = REG_DEFAULT;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    // Device reset needs link clocks, so a reset frame spans its release.
    fork
      req(1'b0, 1'b1, 7'h00, 5'h00, 16'h0000, 8'h01);
      begin
        repeat (20) @(posedge link.sck);
        @(posedge clk);
        #1 dev_rst_n = 1'b1;
      end
    join
    repeat (10) @(posedge clk);
    #1 quiet = 1'b0;
    chk_rst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      a[i] = 5'($random(seed));
      if (a[i] == TRI_REG_ADDR) a[i] = 5'h00;
      wr(a[i], 16'($random(seed)), 7'h00, 8'h01, 1'b1);
    end
    for (int i = 0; i < 4; i++) rd(a[i]);
    wr(5'h05, 16'h1234, 7'h01, 8'h02, 1'b0);
    wr(5'h05, 16'hC3A5, 7'h00, 8'h02, 1'b1);
    wr(5'h06, 16'h5A5A, 7'h01, 8'h02, 1'b0);
    rd(5'h05);
    rd(5'h06);
    wr(TRI_REG_ADDR, 16'h0004, 7'h00, 8'h01, 1'b1);
    repeat (2) @(posedge clk);
    cmp_bit("miso_oe idle", 1'b0, link.miso_oe);
    rd(TRI_REG_ADDR);
    wr(TRI_REG_ADDR, 16'h0000, 7'h00, 8'h01, 1'b1);
    repeat (2) @(posedge clk);
    cmp_bit("miso_oe idle", 1'b1, link.miso_oe);
    wr(TRI_REG_ADDR, 16'h0004, 7'h00, 8'h01, 1'b1);
    wr(5'h03, 16'hA5C3, 7'h00, 8'h01, 1'b1);
    rs_exp += 2; // Both slots of an all-zero frame are reset commands.
    req(1'b0, 1'b1, 7'h00, 5'h00, 16'h0000, 8'h01);
    foreach (mem[i]) mem[i] = REG_DEFAULT;
    rd(5'h03);
    rd(TRI_REG_ADDR);
    repeat (20) @(posedge clk);
    cmp_word("reads left", 16'h0000, 16'(rd_q.size()));
    cmp_word("writes left", 16'h0000, 16'(wr_q.size()));
    cmp_word("resets left", 16'h0000, 16'(rs_exp));
    close_out();
  end

endmodule

`default_nettype wire
